// ---- shared/write_lock_params.svh ----
// Constants for the register write lock
// Overview of operation
// - Reset leaves all protected registers locked.
// - Keys 59h, 16h, 88h in turn unlock.
// - Wrong value or other write aborts sequence.
// - Key read bit 0 shows unlocked status.
// - Any key write while unlocked relocks.
// - Locked writes to protected bits dropped.
// - Key takes byte code, reads only status.
// - Power control bit 6 always writable.
// - Only listed bits of partial registers guarded.
// - Guarded registers sit at fixed addresses.
`ifndef WRITE_LOCK_PARAMS_SVH
`define WRITE_LOCK_PARAMS_SVH

`define WL_KEY_ADDR        32'h5000_0100
`define WL_KEY_RESET       32'h0000_0000
`define WL_KEY_BYTE0       8'h59
`define WL_KEY_BYTE1       8'h16
`define WL_KEY_BYTE2       8'h88
`define WL_KEY_MSB         7
`define WL_STATUS_BIT      0
`define WL_NUM_PROT        12
`define WL_CTRL_RESET      32'h0000_0000

`define WL_ADDR_PRST       32'h5000_0008
`define WL_ADDR_BROWN      32'h5000_0018
`define WL_ADDR_PORDIS     32'h5000_0024
`define WL_ADDR_PWR        32'h5000_0200
`define WL_ADDR_CLKGATE    32'h5000_0208
`define WL_ADDR_CLOCK_SELECT_FIRST    32'h5000_0210
`define WL_ADDR_CLOCK_SELECT_SECOND    32'h5000_0214
`define WL_ADDR_NMI        32'h5000_0380
`define WL_ADDR_FLCTRL     32'h5000_C000
`define WL_ADDR_FLTRIG     32'h5000_C010
`define WL_ADDR_FLTIME     32'h5000_C018
`define WL_ADDR_WDOG       32'h4000_4000

`define WL_MASK_PRST       32'h0000_000F
`define WL_MASK_BROWN      32'h0000_00AF
`define WL_MASK_PORDIS     32'h0000_FFFF
`define WL_MASK_PWR        32'h0000_01BF
`define WL_MASK_CLKGATE    32'h0000_0001
`define WL_MASK_CLOCK_SELECT_FIRST    32'h0000_003F
`define WL_MASK_CLOCK_SELECT_SECOND    32'h0000_0003
`define WL_MASK_NMI        32'h0000_0100
`define WL_MASK_FLCTRL     32'h0000_007B
`define WL_MASK_FLTRIG     32'h0000_0001
`define WL_MASK_FLTIME     32'h0000_0010
`define WL_MASK_WDOG       32'h8000_07D2

`endif

// ---- shared/write_lock_pkg.sv ----
// Types shared by the register write lock
package write_lock_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_ACK  = 2'b10
    } bus_phase_e;

    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_GOT1 = 2'b01,
        LOCK_GOT2 = 2'b10,
        LOCK_OPEN = 2'b11
    } lock_state_e;

    typedef struct packed {
        logic        wr;
        logic [3:0]  index;
        logic [31:0] wdata;
        logic [31:0] wmask;
    } mem_req_s;

    typedef struct packed {
        bus_phase_e  phase;
        lock_state_e lock;
        logic [31:0] rdata;
        logic        slverr;
    } lock_regs_s;

endpackage

// ---- rtl/write_lock_bank.sv ----
// Storage for the guarded control registers
`timescale 1ns/100ps
`include "write_lock_params.svh"

module write_lock_bank #(
    parameter int DEPTH = `WL_NUM_PROT,
    parameter int WIDTH = 32
) (
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire write_lock_pkg::mem_req_s req,
    input  wire logic [3:0]               rd_index,
    output logic [WIDTH-1:0]              rdata,
    output logic [DEPTH*WIDTH-1:0]        contents
);
    import write_lock_pkg::*;

    generate
        if (WIDTH != 32 || DEPTH < 1 || DEPTH > 16) begin : bad_shape
            $error("write_lock_bank: WIDTH must be 32 and DEPTH 1 to 16");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] word;
        logic [WIDTH-1:0]            rdata;
    } bank_s;

    bank_s state;
    bank_s next_state;

    always_comb begin
        next_state = state;
        for (int i = 0; i < DEPTH; i++) begin
            if (req.wr && req.index == 4'(i)) begin
                next_state.word[i] = (state.word[i] & ~req.wmask) | (req.wdata & req.wmask);
            end
        end
        if (32'(rd_index) < 32'(DEPTH)) begin
            next_state.rdata = state.word[rd_index];
        end else begin
            next_state.rdata = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                state.word[i] <= `WL_CTRL_RESET;
            end
            state.rdata <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;

    generate
        for (genvar g = 0; g < DEPTH; g++) begin : flat
            assign contents[g*WIDTH +: WIDTH] = state.word[g];
        end
    endgenerate

endmodule // write_lock_bank

// ---- rtl/register_write_lock.sv ----
// Register write lock with key sequence and guarded register bank
`timescale 1ns/100ps
`include "write_lock_params.svh"

module register_write_lock (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             unlocked_status,
    output logic [31:0]      peripheral_reset_ctrl,
    output logic [31:0]      brownout_ctrl,
    output logic [31:0]      poweron_reset_disable,
    output logic [31:0]      power_ctrl,
    output logic [31:0]      peripheral_clock_gate,
    output logic [31:0]      clock_select_first,
    output logic [31:0]      clock_select_second,
    output logic [31:0]      nmi_source_select,
    output logic [31:0]      flash_program_ctrl,
    output logic [31:0]      flash_program_trigger,
    output logic [31:0]      flash_access_timing,
    output logic [31:0]      watchdog_ctrl
);
    import write_lock_pkg::*;

    localparam int NPROT = `WL_NUM_PROT;

    // Guarded address lookup: hit flag and bank index
    function automatic logic [4:0] decode_prot(input logic [31:0] a);
        logic [4:0] r;
        r = 5'h00;
        case (a)
            `WL_ADDR_PRST:    r = {1'b1, 4'h0};
            `WL_ADDR_BROWN:   r = {1'b1, 4'h1};
            `WL_ADDR_PORDIS:  r = {1'b1, 4'h2};
            `WL_ADDR_PWR:     r = {1'b1, 4'h3};
            `WL_ADDR_CLKGATE: r = {1'b1, 4'h4};
            `WL_ADDR_CLOCK_SELECT_FIRST: r = {1'b1, 4'h5};
            `WL_ADDR_CLOCK_SELECT_SECOND: r = {1'b1, 4'h6};
            `WL_ADDR_NMI:     r = {1'b1, 4'h7};
            `WL_ADDR_FLCTRL:  r = {1'b1, 4'h8};
            `WL_ADDR_FLTRIG:  r = {1'b1, 4'h9};
            `WL_ADDR_FLTIME:  r = {1'b1, 4'hA};
            `WL_ADDR_WDOG:    r = {1'b1, 4'hB};
            default:          r = 5'h00;
        endcase
        return r;
    endfunction

    // Bits of each guarded register that obey the lock
    function automatic logic [31:0] prot_mask(input logic [3:0] idx);
        logic [31:0] m;
        m = 32'h0000_0000;
        case (idx)
            4'h0:    m = `WL_MASK_PRST;
            4'h1:    m = `WL_MASK_BROWN;
            4'h2:    m = `WL_MASK_PORDIS;
            4'h3:    m = `WL_MASK_PWR;
            4'h4:    m = `WL_MASK_CLKGATE;
            4'h5:    m = `WL_MASK_CLOCK_SELECT_FIRST;
            4'h6:    m = `WL_MASK_CLOCK_SELECT_SECOND;
            4'h7:    m = `WL_MASK_NMI;
            4'h8:    m = `WL_MASK_FLCTRL;
            4'h9:    m = `WL_MASK_FLTRIG;
            4'hA:    m = `WL_MASK_FLTIME;
            4'hB:    m = `WL_MASK_WDOG;
            default: m = 32'h0000_0000;
        endcase
        return m;
    endfunction

    lock_regs_s            state;
    lock_regs_s            next_state;
    mem_req_s              mem_req;
    logic [31:0]           mem_rdata;
    logic [NPROT*32-1:0]   contents;
    logic [4:0]            prot_hit;
    logic                  key_hit;
    logic                  is_open;
    logic                  commit_wr;
    logic [7:0]            key_byte;

    // Address and status decode
    assign prot_hit  = decode_prot(paddr);
    assign key_hit   = (paddr == `WL_KEY_ADDR);
    assign is_open   = (state.lock == LOCK_OPEN);
    assign key_byte  = pwdata[`WL_KEY_MSB:0];
    assign commit_wr = (state.phase == BUS_ACK) && psel && penable && pwrite;

    // Bank write port
    always_comb begin
        mem_req       = '0;
        mem_req.index = prot_hit[3:0];
        mem_req.wdata = pwdata;
        mem_req.wr    = commit_wr && prot_hit[4];
        if (is_open) begin
            mem_req.wmask = 32'hFFFF_FFFF;
        end else begin
            mem_req.wmask = ~prot_mask(prot_hit[3:0]);
        end
    end

    // Bus phase, read data and key sequence
    always_comb begin
        next_state = state;
        case (state.phase)
            BUS_IDLE: begin
                if (psel && !penable) begin
                    next_state.phase = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                next_state.phase  = BUS_ACK;
                next_state.slverr = !(key_hit || prot_hit[4]);
                if (pwrite) begin
                    next_state.rdata = 32'h0000_0000;
                end else if (key_hit) begin
                    next_state.rdata = 32'h0000_0000;
                    next_state.rdata[`WL_STATUS_BIT] = is_open;
                end else if (prot_hit[4]) begin
                    next_state.rdata = mem_rdata;
                end else begin
                    next_state.rdata = 32'h0000_0000;
                end
            end
            BUS_ACK: begin
                next_state.phase  = BUS_IDLE;
                next_state.slverr = 1'b0;
            end
            default: begin
                next_state.phase = BUS_IDLE;
            end
        endcase

        if (commit_wr) begin
            if (key_hit) begin
                case (state.lock)
                    LOCK_OPEN: begin
                        next_state.lock = LOCK_IDLE;
                    end
                    LOCK_GOT1: begin
                        if (key_byte == `WL_KEY_BYTE1) begin
                            next_state.lock = LOCK_GOT2;
                        end else if (key_byte == `WL_KEY_BYTE0) begin
                            next_state.lock = LOCK_GOT1;
                        end else begin
                            next_state.lock = LOCK_IDLE;
                        end
                    end
                    LOCK_GOT2: begin
                        if (key_byte == `WL_KEY_BYTE2) begin
                            next_state.lock = LOCK_OPEN;
                        end else if (key_byte == `WL_KEY_BYTE0) begin
                            next_state.lock = LOCK_GOT1;
                        end else begin
                            next_state.lock = LOCK_IDLE;
                        end
                    end
                    LOCK_IDLE: begin
                        if (key_byte == `WL_KEY_BYTE0) begin
                            next_state.lock = LOCK_GOT1;
                        end else begin
                            next_state.lock = LOCK_IDLE;
                        end
                    end
                    default: begin
                        next_state.lock = LOCK_IDLE;
                    end
                endcase
            end else if (state.lock == LOCK_GOT1 || state.lock == LOCK_GOT2) begin
                next_state.lock = LOCK_IDLE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state.phase  <= BUS_IDLE;
            state.lock   <= LOCK_IDLE;
            state.rdata  <= `WL_KEY_RESET;
            state.slverr <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    write_lock_bank #(
        .DEPTH (NPROT),
        .WIDTH (32)
    ) bank (
        .clock    (clock),
        .rst      (rst),
        .req      (mem_req),
        .rd_index (prot_hit[3:0]),
        .rdata    (mem_rdata),
        .contents (contents)
    );

    // Bus answers
    assign pready          = (state.phase == BUS_ACK);
    assign pslverr         = (state.phase == BUS_ACK) && state.slverr;
    assign prdata          = state.rdata;
    assign unlocked_status = is_open;

    // Guarded register contents
    assign peripheral_reset_ctrl = contents[0*32 +: 32];
    assign brownout_ctrl         = contents[1*32 +: 32];
    assign poweron_reset_disable = contents[2*32 +: 32];
    assign power_ctrl            = contents[3*32 +: 32];
    assign peripheral_clock_gate = contents[4*32 +: 32];
    assign clock_select_first    = contents[5*32 +: 32];
    assign clock_select_second   = contents[6*32 +: 32];
    assign nmi_source_select     = contents[7*32 +: 32];
    assign flash_program_ctrl    = contents[8*32 +: 32];
    assign flash_program_trigger = contents[9*32 +: 32];
    assign flash_access_timing   = contents[10*32 +: 32];
    assign watchdog_ctrl         = contents[11*32 +: 32];

endmodule // register_write_lock

// ---- bench/write_lock_checker_assertions.sv ----
// Port checks for the register write lock
`timescale 1ns/100ps
`include "write_lock_params.svh"

module write_lock_checker (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        unlocked_status,
    input wire logic [31:0] power_ctrl,
    input wire logic [31:0] clock_select_second,
    input wire logic [31:0] watchdog_ctrl
);
    logic wr_done;
    logic wr_key;
    logic wr_last;
    logic wr_sel2;
    logic open_ok;
    logic [1:0] key_step;
    assign wr_done = pready && pwrite;
    assign wr_key  = wr_done && paddr == `WL_KEY_ADDR;
    assign wr_last = wr_key && pwdata[7:0] == `WL_KEY_BYTE2;
    assign wr_sel2 = wr_done && paddr == `WL_ADDR_CLOCK_SELECT_SECOND;
    assign open_ok = wr_last && key_step == 2'h2;
    // Key bytes seen so far in an unbroken sequence
    always_ff @(posedge clock) begin
        if (rst) begin
            key_step <= 2'h0;
        end else if (wr_done) begin
            if (!wr_key || unlocked_status) begin
                key_step <= 2'h0;
            end else if (key_step == 2'h1 && pwdata[7:0] == `WL_KEY_BYTE1) begin
                key_step <= 2'h2;
            end else if (pwdata[7:0] == `WL_KEY_BYTE0) begin
                key_step <= 2'h1;
            end else begin
                key_step <= 2'h0;
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_one_wait:
        assert property (psel && !penable |=> !pready ##1 pready) else $error("late answer");
    a_reset_locked:
        assert property ($fell(rst) |-> !unlocked_status) else $error("open after reset");
    a_open_final:
        assert property ($rose(unlocked_status) |-> $past(open_ok)) else $error("bad open");
    a_seq_opens:
        assert property (open_ok && !unlocked_status |=> unlocked_status)
        else $error("no open");
    a_key_status:
        assert property (pready && !pwrite && paddr == `WL_KEY_ADDR
            |-> prdata == {31'h0, unlocked_status}) else $error("key read wrong");
    a_relock:
        assert property (wr_key && unlocked_status |=> !unlocked_status) else $error("no relock");
    a_locked_drop:
        assert property (wr_sel2 && !unlocked_status |=> $stable(clock_select_second[1:0]))
        else $error("locked bits written");
    a_free_bits:
        assert property (wr_sel2 |=> clock_select_second[31:2] == $past(pwdata[31:2]))
        else $error("free bits lost");
    a_wake_free:
        assert property (wr_done && paddr == `WL_ADDR_PWR |=> power_ctrl[6] == $past(pwdata[6]))
        else $error("wake bit lost");
    a_wdog_hold:
        assert property (!wr_done |=> $stable(watchdog_ctrl)) else $error("stray change");
endmodule // write_lock_checker

bind register_write_lock write_lock_checker write_lock_checker_inst (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .unlocked_status(unlocked_status), .power_ctrl(power_ctrl),
    .clock_select_second(clock_select_second), .watchdog_ctrl(watchdog_ctrl)
);

// ---- bench/apb_host_model.sv ----
// Bus master model standing in for the processor core
`timescale 1ns/100ps

module apb_host_model (
    input  wire logic        clock,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end

    // One transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_host_model

// ---- bench/register_write_lock_test.sv ----
// Self-checking bench for the register write lock
`timescale 1ns/100ps
`include "write_lock_params.svh"

module register_write_lock_test;
    typedef struct {
        logic [31:0] addr;
        logic [31:0] mask;
    } guard_row_s;
    localparam logic [31:0] KEY = `WL_KEY_ADDR;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr, unlocked_status;
    logic [31:0] paddr, pwdata, prdata;
    logic [31:0] regs [12];
    logic [31:0] model [12] = '{default: 32'h0};
    int          n_mismatch = 0;
    int          num_checks = 0;
    guard_row_s  rows [12] = '{
        '{`WL_ADDR_PRST, `WL_MASK_PRST}, '{`WL_ADDR_BROWN, `WL_MASK_BROWN},
        '{`WL_ADDR_PORDIS, `WL_MASK_PORDIS}, '{`WL_ADDR_PWR, `WL_MASK_PWR},
        '{`WL_ADDR_CLKGATE, `WL_MASK_CLKGATE}, '{32'h5000_0210, 32'h0000_003F},
        '{32'h5000_0214, 32'h0000_0003}, '{`WL_ADDR_NMI, `WL_MASK_NMI},
        '{`WL_ADDR_FLCTRL, `WL_MASK_FLCTRL}, '{`WL_ADDR_FLTRIG, `WL_MASK_FLTRIG},
        '{`WL_ADDR_FLTIME, `WL_MASK_FLTIME}, '{`WL_ADDR_WDOG, `WL_MASK_WDOG}
    };

    always #10 clock = ~clock;

    register_write_lock register_write_lock_inst (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .unlocked_status(unlocked_status),
        .peripheral_reset_ctrl(regs[0]), .brownout_ctrl(regs[1]),
        .poweron_reset_disable(regs[2]), .power_ctrl(regs[3]),
        .peripheral_clock_gate(regs[4]), .clock_select_first(regs[5]),
        .clock_select_second(regs[6]), .nmi_source_select(regs[7]),
        .flash_program_ctrl(regs[8]), .flash_program_trigger(regs[9]),
        .flash_access_timing(regs[10]), .watchdog_ctrl(regs[11])
    );

    apb_host_model apb_host_model_inst (
        .clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb_host_model_inst.xfer(w, a, d, r, e);
        if (!w) begin
            check("read data", exp, r);
        end
        check("slave error", {31'h0, err}, {31'h0, e});
    endtask

    task automatic key(input logic [7:0] b);
        xfer(1'b1, KEY, {24'hA5A5A5, b}, 32'h0, 1'b0);
    endtask

    task automatic status(input logic s);
        xfer(1'b0, KEY, 32'h0, {31'h0, s}, 1'b0);
        check("unlocked status", {31'h0, s}, {31'h0, unlocked_status});
    endtask

    task automatic unlock();
        key(`WL_KEY_BYTE0);
        key(`WL_KEY_BYTE1);
        key(`WL_KEY_BYTE2);
    endtask

    task automatic sweep(input logic [31:0] d, input logic open);
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].addr, d, 32'h0, 1'b0);
            model[i] = open ? d : (d & ~rows[i].mask) | (model[i] & rows[i].mask);
            @(negedge clock);
            check("guarded register", model[i], regs[i]);
            xfer(1'b0, rows[i].addr, 32'h0, model[i], 1'b0);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        foreach (regs[i]) begin
            check("reset value", 32'h0, regs[i]);
        end
        status(1'b0);
        sweep(32'hFFFF_FFFF, 1'b0);
        unlock();
        status(1'b1);
        sweep(32'hFFFF_FFFF, 1'b1);
        key(`WL_KEY_BYTE0);
        status(1'b0);
        sweep(32'h0, 1'b0);
        // Wrong value mid-sequence
        key(`WL_KEY_BYTE0);
        key(`WL_KEY_BYTE1);
        key(8'h77);
        key(`WL_KEY_BYTE2);
        status(1'b0);
        // Unmapped read, then unmapped write mid-sequence
        xfer(1'b0, KEY + 32'h4, 32'h0, 32'h0, 1'b1);
        key(`WL_KEY_BYTE0);
        xfer(1'b1, KEY + 32'h4, 32'h0, 32'h0, 1'b1);
        key(`WL_KEY_BYTE1);
        key(`WL_KEY_BYTE2);
        status(1'b0);
        // Non-key value while locked
        key(`WL_KEY_BYTE0);
        key(8'h00);
        key(`WL_KEY_BYTE1);
        key(`WL_KEY_BYTE2);
        status(1'b0);
        // First byte written again mid-sequence starts afresh
        key(`WL_KEY_BYTE0);
        key(`WL_KEY_BYTE1);
        unlock();
        status(1'b1);
        // Reset while open
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check("reset value", 32'h0, regs[11]);
        status(1'b0);
        stop_test();
    end
endmodule // register_write_lock_test
